// [hw/snh_pkg.sv]
package snh_pkg;

  // instruction codes
  localparam logic [7:0] CMD_WREN  = 8'h06;
  localparam logic [7:0] CMD_WRDI  = 8'h04;
  localparam logic [7:0] CMD_RDSR  = 8'h05;
  localparam logic [7:0] CMD_RDSR2 = 8'h0f;
  localparam logic [7:0] CMD_WRSR  = 8'h01;
  localparam logic [7:0] CMD_WRSR2 = 8'h1f;
  localparam logic [7:0] CMD_PEXE  = 8'h10;
  localparam logic [7:0] CMD_BERS  = 8'hd8;
  localparam logic [7:0] CMD_DREAD = 8'h3b;
  localparam logic [7:0] CMD_DIO   = 8'hbb;
  localparam logic [7:0] CMD_QREAD = 8'h6b;
  localparam logic [7:0] CMD_QIO   = 8'heb;
  localparam logic [7:0] CMD_QLD   = 8'h32;
  localparam logic [7:0] CMD_QLDR  = 8'h34;

  // one-byte register addresses for status commands
  localparam logic [7:0] REG_PROT = 8'ha0;
  localparam logic [7:0] REG_CONF = 8'hb0;
  localparam logic [7:0] REG_STAT = 8'hc0;

  // protection register layout and power-up value
  localparam int P_REG_PROTECT_BIT0  = 7;
  localparam int P_BP_HI = 6;
  localparam int P_BP_LO = 3;
  localparam int P_TB    = 2;
  localparam int P_WPE   = 1;
  localparam int P_REG_PROTECT_BIT1  = 0;
  localparam logic [7:0] PROT_DEFAULT = 8'h78;
  localparam logic [3:0] BP_NONE = 4'h0;
  localparam logic [3:0] BP_ALL  = 4'hb;

  // status register layout
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;

  // address cycles per command shape
  localparam logic [4:0] AC_NONE = 5'h00;
  localparam logic [4:0] AC_SR   = 5'h08;
  localparam logic [4:0] AC_COL  = 5'h10;
  localparam logic [4:0] AC_PG   = 5'h18;
  localparam logic [4:0] AC_DIO  = 5'h0c;
  localparam logic [4:0] AC_QIO  = 5'h06;

  // array geometry
  localparam int PAGE_W = 16;
  localparam int BLK_W  = 10;
  localparam logic [10:0] BLK_NUM = 11'h400;

  // lane output enables, active low
  localparam logic [3:0] OE_N_OFF = 4'hf;
  localparam logic [3:0] OE_N_W1  = 4'hd;
  localparam logic [3:0] OE_N_W2  = 4'hc;
  localparam logic [3:0] OE_N_W4  = 4'h0;

  localparam int CLK_PERIOD_NS = 25;

  typedef enum logic [2:0] {
    PH_CMD  = 3'b000,
    PH_ADDR = 3'b001,
    PH_DIN  = 3'b010,
    PH_DOUT = 3'b011,
    PH_IGN  = 3'b100
  } snh_phase_t;

  typedef enum logic [1:0] {
    W1 = 2'b00,
    W2 = 2'b01,
    W4 = 2'b10
  } snh_width_t;

  typedef struct packed {
    logic       quad;
    logic       arr;
    snh_width_t aw;
    logic [4:0] acyc;
    snh_phase_t nxt;
    snh_width_t dw;
  } snh_cmd_t;

  // synchronised pin bundle
  typedef struct packed {
    logic       vcc;
    logic [3:0] lane;
    logic       cs;
    logic       sclk;
  } snh_pins_t;

endpackage

// [hw/snh_if.sv]
`timescale 1ns/10ps
`default_nettype none

// synchronised pins and link clock edges
interface snh_pin_if;
  logic       sclk_lvl;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic       cs_end;
  logic [3:0] lane;
  logic       vcc_ok;
  modport src (output sclk_lvl, sclk_rise, sclk_fall, cs_act, cs_end,
               lane, vcc_ok);
  modport snk (input sclk_lvl, sclk_rise, sclk_fall, cs_act, cs_end,
               lane, vcc_ok);
endinterface // snh_pin_if

// block protection query
interface snh_prot_if;
  logic [3:0]  bp;
  logic        tb;
  logic [15:0] page;
  logic        blocked;
  modport eval (input bp, tb, page, output blocked);
  modport user (output bp, tb, page, input blocked);
endinterface // snh_prot_if

`default_nettype wire

// [hw/snh_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module snh_pin_sync
  import snh_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] lane_i,
  input  wire logic       vcc_ok,
  snh_pin_if.src          pin
);

  snh_pins_t raw;      // pins as they arrive
  snh_pins_t s1_ff;    // first stage, read only by s2
  snh_pins_t s2_ff;    // second stage, safe to use
  logic      sclk_d_ff; // previous clock level
  logic      cs_d_ff;   // previous select level

  assign raw = '{vcc: vcc_ok, lane: lane_i, cs: ~cs_n, sclk: sclk};

  // two-flop synchroniser; lanes share the clock delay so they stay aligned
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  // edge history of the synchronised levels
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b0;
    end else begin
      sclk_d_ff <= s2_ff.sclk;
      cs_d_ff   <= s2_ff.cs;
    end
  end

  assign pin.sclk_lvl  = s2_ff.sclk;
  assign pin.sclk_rise = s2_ff.sclk & ~sclk_d_ff;
  assign pin.sclk_fall = ~s2_ff.sclk & sclk_d_ff;
  assign pin.cs_act    = s2_ff.cs;
  assign pin.cs_end    = ~s2_ff.cs & cs_d_ff;
  assign pin.lane      = s2_ff.lane;
  assign pin.vcc_ok    = s2_ff.vcc;

endmodule // snh_pin_sync

`default_nettype wire

// [hw/snh_prot_eval.sv]
`timescale 1ns/10ps
`default_nettype none

module snh_prot_eval
  import snh_pkg::*;
(
  snh_prot_if.eval pq
);

  // protected span grows by powers of two; large codes cover all blocks
  function automatic logic blk_hit(input logic [3:0] bp, input logic tb,
                                   input logic [BLK_W-1:0] blk);
    logic [10:0] span;
    logic [10:0] b;
    span = 11'h000;
    b    = {1'b0, blk};
    if (bp >= BP_ALL)
      span = BLK_NUM;
    else if (bp != BP_NONE)
      span = 11'(11'h001 << (bp - 4'h1));
    // tb set protects from the bottom, clear from the top
    if (tb)
      blk_hit = (b < span);
    else
      blk_hit = (b >= 11'(BLK_NUM - span));
  endfunction

  assign pq.blocked = blk_hit(pq.bp, pq.tb,
                              pq.page[PAGE_W-1:PAGE_W-BLK_W]);

endmodule // snh_prot_eval

`default_nettype wire

// [hw/snh_front.sv]
`timescale 1ns/10ps
`default_nettype none

module snh_front
  import snh_pkg::*;
#(
  parameter int PUW_US = 1000
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  lane_i,
  output logic      [3:0]  lane_o,
  output logic      [3:0]  lane_oe_n,
  input  wire logic        vcc_ok,
  input  wire logic        prot_lock,
  input  wire logic [7:0]  prot_locked_val,
  input  wire logic [7:0]  rd_data,
  output logic             rd_take,
  output logic [7:0]       ld_data,
  output logic             ld_valid,
  output logic [15:0]      col_addr,
  output logic             op_start,
  output logic             op_erase,
  output logic [15:0]      op_page,
  input  wire logic        op_done
);

  localparam int LOCK_CYC = (PUW_US * 1000) / CLK_PERIOD_NS;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  snh_pin_if  pin();                 // synchronised link pins
  snh_prot_if pq();                  // block protection query

  snh_phase_t  phase_ff;             // transfer phase
  logic [4:0]  cyc_ff;               // cycles within phase or byte
  logic [23:0] sh_ff;                // incoming shift register
  logic [7:0]  cmd_ff;               // current instruction
  snh_cmd_t    info_ff;              // decoded instruction shape
  logic [7:0]  sr_addr_ff;           // register address byte
  logic [7:0]  osr_ff;               // outgoing byte remainder
  logic [3:0]  lane_o_ff;            // driven lane levels
  logic [3:0]  oe_n_ff;              // lane enables, low drives
  logic [7:0]  wr_val_ff;            // first register data byte
  logic        wr_got_ff;            // data byte received
  logic        paused_ff;            // pause condition active
  logic [31:0] lock_cnt_ff;          // power-up lockout counter
  logic        lockout_ff;           // writes still locked out
  logic        wel_ff;               // write_enable_latch
  logic [7:0]  prot_ff;              // protection_register
  logic        busy_ff;              // array operation running
  logic        rd_take_ff;
  logic        ld_valid_ff;
  logic [7:0]  ld_data_ff;
  logic [15:0] col_ff;
  logic        op_start_ff;
  logic        op_erase_ff;
  logic [15:0] op_page_ff;

  logic        por;                  // power or system reset
  logic        rise_e;               // usable rising link edge
  logic        fall_e;               // usable falling link edge
  snh_width_t  rx_w;                 // lanes sampled this phase
  logic [23:0] nxt_sh;
  snh_cmd_t    nxt_info;
  logic [7:0]  out_b;                // byte feeding the lanes
  logic        hold_en;
  logic        hw_ro;
  logic        srp_ok;
  logic        sr_ok;
  logic        pe_ok;
  logic        wren_go;
  logic        wrdi_go;
  logic        pe_go;
  logic        sr_go;

  snh_pin_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .lane_i   (lane_i),
    .vcc_ok   (vcc_ok),
    .pin      (pin)
  );

  snh_prot_eval u_prot (
    .pq (pq)
  );

  // instruction shape; quad codes are unknown while protect enable is set
  function automatic snh_cmd_t cmd_dec(input logic [7:0] c,
                                       input logic wpe);
    cmd_dec = '{quad: 1'b0, arr: 1'b0, aw: W1, acyc: AC_NONE,
                nxt: PH_IGN, dw: W1};
    unique case (c)
      CMD_RDSR, CMD_RDSR2: begin
        cmd_dec.acyc = AC_SR;
        cmd_dec.nxt  = PH_DOUT;
      end
      CMD_WRSR, CMD_WRSR2: begin
        cmd_dec.acyc = AC_SR;
        cmd_dec.nxt  = PH_DIN;
      end
      CMD_PEXE, CMD_BERS: cmd_dec.acyc = AC_PG;
      CMD_DREAD, CMD_DIO: begin
        cmd_dec = '{quad: 1'b0, arr: 1'b1, aw: W1, acyc: AC_PG,
                    nxt: PH_DOUT, dw: W2};
        if (c == CMD_DIO) begin
          cmd_dec.aw   = W2;
          cmd_dec.acyc = AC_DIO;
        end
      end
      CMD_QREAD, CMD_QIO, CMD_QLD, CMD_QLDR: begin
        if (!wpe) begin
          cmd_dec = '{quad: 1'b1, arr: 1'b1, aw: W1, acyc: AC_PG,
                      nxt: PH_DOUT, dw: W4};
          if (c == CMD_QIO) begin
            cmd_dec.aw   = W4;
            cmd_dec.acyc = AC_QIO;
          end else if (c != CMD_QREAD) begin
            cmd_dec.acyc = AC_COL;
            cmd_dec.nxt  = PH_DIN;
          end
        end
      end
      default: ;
    endcase
  endfunction

  // shift sampled lanes into the register
  function automatic logic [23:0] shin(input logic [23:0] v,
                                       input logic [3:0] ln,
                                       input snh_width_t w);
    unique case (w)
      W2:      shin = {v[21:0], ln[1:0]};
      W4:      shin = {v[19:0], ln};
      default: shin = {v[22:0], ln[0]};
    endcase
  endfunction

  // link cycles per byte
  function automatic logic [4:0] cpb(input snh_width_t w);
    unique case (w)
      W2:      cpb = 5'h04;
      W4:      cpb = 5'h02;
      default: cpb = 5'h08;
    endcase
  endfunction

  // register readback for status reads
  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    reg_rd = 8'h00;
    if (a == REG_PROT)
      reg_rd = prot_ff;
    else if (a == REG_STAT) begin
      reg_rd[ST_BUSY] = busy_ff;
      reg_rd[ST_WEL]  = wel_ff;
    end
  endfunction

  // supply below threshold acts as system reset everywhere but the pin synchroniser
  assign por = srst | ~pin.vcc_ok;
  assign rise_e = pin.sclk_rise & pin.cs_act & ~paused_ff;
  assign fall_e = pin.sclk_fall & pin.cs_act & ~paused_ff;
  assign rx_w = (phase_ff == PH_CMD) ? W1 :
                (phase_ff == PH_ADDR) ? info_ff.aw : info_ff.dw;
  assign nxt_sh = shin(sh_ff, pin.lane, rx_w);
  assign nxt_info = cmd_dec(nxt_sh[7:0], prot_ff[P_WPE]);
  // a process, so that a change of the registers behind reg_rd is seen
  always_comb begin
    out_b = osr_ff;
    if (cyc_ff == 5'h00)
      out_b = info_ff.arr ? rd_data : reg_rd(sr_addr_ff);
  end

  // pause pin is data lane once quad is running
  assign hold_en = ~info_ff.quad | (phase_ff == PH_CMD);

  // pause follows the pin only while the link clock is low
  always_ff @(posedge core_clk) begin
    if (por || !pin.cs_act)
      paused_ff <= 1'b0;
    // change at pin edge or next clock fall
    else if (!pin.sclk_lvl)
      paused_ff <= hold_en & ~pin.lane[3];
  end

  AST_PAUSE_NOCS: assert property (!pin.cs_act |=> !paused_ff)
    else $error("pause while deselected");
  AST_PAUSE_FLOAT: assert property (paused_ff |-> lane_oe_n == OE_N_OFF)
    else $error("lanes driven during pause");
  AST_PAUSE_KEEP: assert property (paused_ff && pin.cs_act && !por |=>
    $stable(phase_ff) && $stable(cyc_ff) && $stable(lane_o_ff))
    else $error("transfer state moved during pause");

  // transfer engine
  always_ff @(posedge core_clk) begin
    rd_take_ff  <= 1'b0;
    ld_valid_ff <= 1'b0;
    if (por || !pin.cs_act) begin
      phase_ff  <= PH_CMD;
      cyc_ff    <= 5'h00;
      sh_ff     <= '0;
      cmd_ff    <= 8'h00;
      info_ff   <= '0;
      oe_n_ff   <= OE_N_OFF;
      lane_o_ff <= '0;
      wr_got_ff <= 1'b0;
    end else if (rise_e) begin
      unique case (phase_ff)
        PH_CMD: begin
          sh_ff  <= nxt_sh;
          cyc_ff <= cyc_ff + 5'h01;
          if (cyc_ff == cpb(W1) - 5'h01) begin
            cmd_ff   <= nxt_sh[7:0];
            info_ff  <= nxt_info;
            cyc_ff   <= 5'h00;
            phase_ff <= (nxt_info.acyc == AC_NONE) ? PH_IGN : PH_ADDR;
          end
        end
        PH_ADDR: begin
          sh_ff  <= nxt_sh;
          cyc_ff <= cyc_ff + 5'h01;
          if (cyc_ff == info_ff.acyc - 5'h01) begin
            cyc_ff   <= 5'h00;
            phase_ff <= info_ff.nxt;
            sr_addr_ff <= nxt_sh[7:0];
            col_ff <= (info_ff.acyc == AC_COL) ? nxt_sh[15:0]
                                               : nxt_sh[23:8];
          end
        end
        PH_DIN: begin
          sh_ff  <= nxt_sh;
          cyc_ff <= cyc_ff + 5'h01;
          if (cyc_ff == cpb(info_ff.dw) - 5'h01) begin
            cyc_ff <= 5'h00;
            if (info_ff.quad) begin
              ld_valid_ff <= 1'b1;
              ld_data_ff  <= nxt_sh[7:0];
            end else if (!wr_got_ff) begin
              wr_val_ff <= nxt_sh[7:0];
              wr_got_ff <= 1'b1;
            end
          end
        end
        default: ;
      endcase
    end else if (fall_e && phase_ff == PH_DOUT) begin
      rd_take_ff <= info_ff.arr & (cyc_ff == 5'h00);
      cyc_ff <= (cyc_ff == cpb(info_ff.dw) - 5'h01) ? 5'h00
                                                    : cyc_ff + 5'h01;
      unique case (info_ff.dw)
        W2: begin
          lane_o_ff <= {2'b00, out_b[7:6]};
          oe_n_ff   <= OE_N_W2;
          osr_ff    <= {out_b[5:0], 2'b00};
        end
        W4: begin
          lane_o_ff <= out_b[7:4];
          oe_n_ff   <= OE_N_W4;
          osr_ff    <= {out_b[3:0], 4'h0};
        end
        default: begin
          lane_o_ff <= {2'b00, out_b[7], 1'b0};
          oe_n_ff   <= OE_N_W1;
          osr_ff    <= {out_b[6:0], 1'b0};
        end
      endcase
    end
  end

  // lockout delay after supply is good
  always_ff @(posedge core_clk) begin
    if (por) begin
      lock_cnt_ff <= 32'h0;
      lockout_ff  <= 1'b1;
    end else if (lock_cnt_ff == 32'(LOCK_CYC - 1)) begin
      lockout_ff <= 1'b0;
    end else begin
      lock_cnt_ff <= lock_cnt_ff + 32'h1;
    end
  end

  assign hw_ro = prot_ff[P_WPE] & ~pin.lane[2];
  always_comb begin
    if (prot_ff[P_WPE])
      srp_ok = ~prot_ff[P_REG_PROTECT_BIT1];
    else if (prot_ff[P_REG_PROTECT_BIT1])
      srp_ok = 1'b0;
    else
      srp_ok = ~prot_ff[P_REG_PROTECT_BIT0] | pin.lane[2];
  end
  assign sr_ok = wel_ff & ~lockout_ff & ~prot_lock & ~hw_ro & srp_ok;
  assign pe_ok = wel_ff & ~lockout_ff & ~hw_ro & ~pq.blocked & ~busy_ff;
  assign pq.bp   = prot_ff[P_BP_HI:P_BP_LO];
  assign pq.tb   = prot_ff[P_TB];
  assign pq.page = sh_ff[15:0];

  // commands take effect when select is released
  assign wren_go = pin.cs_end & (phase_ff == PH_IGN) &
                   (cmd_ff == CMD_WREN) & ~lockout_ff;
  assign wrdi_go = pin.cs_end & (phase_ff == PH_IGN) &
                   (cmd_ff == CMD_WRDI);
  assign pe_go = pin.cs_end & (phase_ff == PH_IGN) & pe_ok &
                 ((cmd_ff == CMD_PEXE) | (cmd_ff == CMD_BERS));
  assign sr_go = pin.cs_end & wr_got_ff & (sr_addr_ff == REG_PROT) &
                 sr_ok & ((cmd_ff == CMD_WRSR) | (cmd_ff == CMD_WRSR2));

  // write_enable_latch; a set wins over a completion clear
  always_ff @(posedge core_clk) begin
    if (por)
      wel_ff <= 1'b0;
    else if (wren_go)
      wel_ff <= 1'b1;
    else if (wrdi_go || op_done)
      wel_ff <= 1'b0;
  end

  AST_WEL_PWRUP: assert property (!pin.vcc_ok |=> !wel_ff)
    else $error("latch set during power-up");
  AST_WEL_DONE: assert property (op_done && !wren_go |=> !wel_ff)
    else $error("latch survived completion");
  AST_WEL_LOCK: assert property ($rose(wel_ff) |-> !$past(lockout_ff))
    else $error("write enable accepted in lockout");

  // protection_register; refused writes leave it untouched
  always_ff @(posedge core_clk) begin
    if (por) begin
      prot_ff <= prot_lock ? prot_locked_val : PROT_DEFAULT;
      if (prot_lock && prot_locked_val[P_REG_PROTECT_BIT1] &&
          !prot_locked_val[P_REG_PROTECT_BIT0]) begin
        prot_ff[P_REG_PROTECT_BIT1] <= 1'b0;
        prot_ff[P_REG_PROTECT_BIT0] <= 1'b0;
      end
    end else if (sr_go) begin
      prot_ff <= wr_val_ff;
    end
  end

  AST_PROT_PWRUP: assert property (
    !pin.vcc_ok && !prot_lock |=>
    prot_ff[P_BP_HI:P_BP_LO] == 4'hf)
    else $error("array not fully protected at power-up");
  AST_PROT_GATE: assert property (
    pin.vcc_ok && $changed(prot_ff) |-> $past(sr_ok))
    else $error("register changed without permission");

  // array operation request and busy tracking
  always_ff @(posedge core_clk) begin
    op_start_ff <= pe_go;
    if (pe_go) begin
      op_erase_ff <= (cmd_ff == CMD_BERS);
      op_page_ff  <= sh_ff[15:0];
    end
    if (por)
      busy_ff <= 1'b0;
    else if (pe_go)
      busy_ff <= 1'b1;
    else if (op_done)
      busy_ff <= 1'b0;
  end

  AST_OP_WEL: assert property (
    op_start |-> $past(wel_ff) && !$past(lockout_ff))
    else $error("operation started without write enable");
  AST_OP_RO: assert property (
    op_start |-> !$past(hw_ro) && !$past(pq.blocked))
    else $error("operation started on protected target");

  assign lane_o    = lane_o_ff;
  assign lane_oe_n = paused_ff ? OE_N_OFF : oe_n_ff;
  assign rd_take   = rd_take_ff;
  assign ld_valid  = ld_valid_ff;
  assign ld_data   = ld_data_ff;
  assign col_addr  = col_ff;
  assign op_start  = op_start_ff;
  assign op_erase  = op_erase_ff;
  assign op_page   = op_page_ff;

endmodule // snh_front

`default_nettype wire

// [sim/snh_host.sv]
`timescale 1ns/10ps
`default_nettype none

// host controller model: mode 0, msb first on lane0, 200 ns link clock
module snh_host (
  input  wire logic       core_clk,
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] lane_i,
  input  wire logic [3:0] lane_o,
  input  wire logic [3:0] lane_oe_n
);
  logic       mosi;     // host data bit
  logic       wp_n;     // write-protect level, set by the bench
  logic       hold_n;   // pause pin level
  logic [3:0] hold_oe;  // lane enables seen while paused
  logic [3:0] last_oe;  // lane enables at the last read sample
  // released lane1 shows the inverse of its last level
  assign lane_i = {hold_n, wp_n,
                   lane_oe_n[1] ? ~lane_o[1] : lane_o[1], mosi};

  // idle: clock low, deselected, pause pin high
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
    wp_n    = 1'b1;
    hold_n  = 1'b1;
    hold_oe = 4'h0;
    last_oe = 4'hf;
  end

  // half a link clock period
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask

  // one framed command: nw bits out, then nr bits in from lane1;
  // read bit hp (if any) is stretched by a pause with one dummy clock
  task automatic frame(input logic [31:0] w, input int nw, input int nr,
                       input int hp, output logic [7:0] r);
    int i;
    r = 8'h00;
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (i = nw - 1; i >= 0; i--) begin
      // data changes on the fall, device samples on the rise
      sclk <= 1'b0;
      mosi <= w[i];
      half();
      sclk <= 1'b1;
      half();
    end
    for (i = 0; i < nr; i++) begin
      sclk <= 1'b0;
      half();
      if (i == hp) begin
        // select stays low for the whole pause
        hold_n <= 1'b0;
        half();
        hold_oe = lane_oe_n;
        // a clock that the paused device must ignore
        sclk <= 1'b1;
        half();
        sclk <= 1'b0;
        half();
        hold_n <= 1'b1;
        half();
      end
      sclk <= 1'b1;
      half();
      // late in the high phase, long after the device drove it
      r = {r[6:0], lane_o[1]};
      last_oe = lane_oe_n;
    end
    sclk <= 1'b0;
    half();
    cs_n <= 1'b1;
    half();
    half();
  endtask
endmodule // snh_host

`default_nettype wire

// [sim/snh_front_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module snh_front_tb
  import snh_pkg::*;
;
  logic        core_clk, srst, vcc_ok, op_done;
  logic        sclk, cs_n;
  logic [3:0]  lane_i, lane_o, lane_oe_n;
  logic        op_start, op_erase;
  logic [7:0]  r;
  logic [15:0] op_page;
  logic        prot_lock;                    // lock bit fed to the design
  logic [7:0]  lock_val;                     // locked register copy
  localparam logic [7:0] RD_BYTE  = 8'h9c;   // array byte for reads
  localparam logic [7:0] LOCK_VAL = 8'h41;   // locked copy, pair (1,0)
  int          n_errors = 0, tests_run = 0, n_start = 0, cyc = 0;

  snh_front #(.PUW_US(1)) snh_front_i (
    .core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
    .lane_i(lane_i), .lane_o(lane_o), .lane_oe_n(lane_oe_n),
    .vcc_ok(vcc_ok), .prot_lock(prot_lock), .prot_locked_val(lock_val),
    .rd_data(RD_BYTE), .rd_take(), .ld_data(), .ld_valid(),
    .col_addr(), .op_start(op_start), .op_erase(op_erase),
    .op_page(op_page), .op_done(op_done));

  snh_host snh_host_i (
    .core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .lane_i(lane_i),
    .lane_o(lane_o), .lane_oe_n(lane_oe_n));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // accepted operations counted; hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (op_start === 1'b1) n_start <= n_start + 1;
    if (cyc == 30000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [31:0] w, input int nw);
    snh_host_i.frame(w, nw, 0, -1, r);
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [7:0] exp);
    snh_host_i.frame({16'h0, CMD_RDSR, a}, 16, 8, -1, r);
    chk({8'h0, r}, {8'h0, exp});
  endtask
  task automatic wrreg(input logic [7:0] d);
    cmd({8'h0, CMD_WRSR, REG_PROT, d}, 24);
  endtask
  task automatic wren();
    cmd({24'h0, CMD_WREN}, 8);
  endtask
  // issue program/erase and expect accepted or not
  task automatic op(input logic [7:0] c, input logic [15:0] pg,
                    input logic ok);
    int s;
    s = n_start;
    cmd({c, 8'h00, pg}, 32);
    chk(16'(n_start - s), {15'h0, ok});
    if (ok) chk({op_erase, op_page[14:0]}, {c == CMD_BERS, pg[14:0]});
  endtask
  task automatic finish_op();
    @(posedge core_clk) op_done <= 1'b1;
    @(posedge core_clk) op_done <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic t_reset();
    rdreg(REG_PROT, PROT_DEFAULT);
    rdreg(REG_STAT, 8'h00);
  endtask
  // dual and quad reads, then a pause in the middle of a status read
  task automatic t_lanes();
    logic [3:0] ex;
    ex = {RD_BYTE[7], RD_BYTE[5], RD_BYTE[3], RD_BYTE[1]};
    snh_host_i.frame({CMD_DREAD, 24'h0}, 32, 4, -1, r);
    chk(16'(r), 16'(ex));
    chk(16'(snh_host_i.last_oe), 16'(OE_N_W2));
    snh_host_i.frame({CMD_QREAD, 24'h0}, 32, 2, -1, r);
    chk(16'(r), 16'({RD_BYTE[5], RD_BYTE[1]}));
    chk(16'(snh_host_i.last_oe), 16'(OE_N_W4));
    snh_host_i.frame({16'h0, CMD_RDSR, REG_PROT}, 16, 8, 3, r);
    chk(16'(r), 16'(PROT_DEFAULT));
    chk(16'(snh_host_i.hold_oe), 16'(OE_N_OFF));
  endtask
  task automatic t_srwrite();
    wrreg(8'h00);
    rdreg(REG_PROT, PROT_DEFAULT);
    wren();
    rdreg(REG_STAT, 8'(1 << ST_WEL));
    wrreg(8'h00);
    rdreg(REG_PROT, 8'h00);
  endtask
  task automatic t_prog();
    op(CMD_PEXE, 16'h0123, 1'b1);
    finish_op();
    rdreg(REG_STAT, 8'h00);
    op(CMD_PEXE, 16'h0123, 1'b0);
  endtask
  task automatic t_wp();
    wren();
    wrreg(PROT_DEFAULT);
    op(CMD_BERS, 16'h0040, 1'b0);
    wrreg(8'(1 << P_WPE));
    snh_host_i.frame({CMD_QREAD, 24'h0}, 32, 2, -1, r);
    chk(16'(snh_host_i.last_oe), 16'(OE_N_OFF));
    @(posedge core_clk) snh_host_i.wp_n <= 1'b0;
    op(CMD_BERS, 16'h0040, 1'b0);
    @(posedge core_clk) snh_host_i.wp_n <= 1'b1;
    op(CMD_BERS, 16'h0040, 1'b1);
    finish_op();
  endtask
  task automatic t_lockdown();
    wren();
    wrreg(8'(1 << P_REG_PROTECT_BIT1));
    rdreg(REG_PROT, 8'(1 << P_REG_PROTECT_BIT1));
    pwr_cycle();
    rdreg(REG_PROT, PROT_DEFAULT);
    rdreg(REG_STAT, 8'h00);
    // a locked copy in lock-down state returns with the pair cleared
    @(posedge core_clk) begin
      prot_lock <= 1'b1;
      lock_val  <= LOCK_VAL;
    end
    pwr_cycle();
    rdreg(REG_PROT, LOCK_VAL & ~8'(1 << P_REG_PROTECT_BIT1));
  endtask
  // supply dip of 8 cycles, then the lockout waited out
  task automatic pwr_cycle();
    @(posedge core_clk) vcc_ok <= 1'b0;
    repeat (8) @(posedge core_clk);
    vcc_ok <= 1'b1;
    repeat (100) @(posedge core_clk);
  endtask

  // reset, wait out the lockout, then the scenarios
  initial begin
    srst = 1'b1;
    vcc_ok = 1'b1;
    op_done = 1'b0;
    prot_lock = 1'b0;
    lock_val = 8'h00;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (100) @(posedge core_clk);
    t_reset();
    t_lanes();
    t_srwrite();
    t_prog();
    t_wp();
    t_lockdown();
    close_out();
  end
endmodule // snh_front_tb

`default_nettype wire
